// [mip_checker.sv]
// Checker of the vector offers at the prioritizer's core-side ports.
// Assumes the bind below, sys_clk domain, rst_b active low.
`timescale 1ns/1ps
`include "mip_consts.svh"
module mip_checker (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic [15:0]       irq_cond,
  input wire logic              nmi_cond,
  input wire mip_pkg::mip_vec_t vec_out,
  input wire logic              vec_ack,
  input wire logic              vec_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // An offer always names a real class
  AST_CLS_REAL: assert property (vec_out.valid |-> vec_out.cls != mip_pkg::MIP_CLS_NONE
    && vec_out.cls <= mip_pkg::MIP_CLS_NMI) else $error("offer with no class");
  // Loaded vector is withdrawn at once
  AST_ACK_DROP: assert property (vec_ack && vec_out.valid |=> !vec_out.valid)
    else $error("offer stayed after load");
  // No condition, no offer
  AST_NO_COND: assert property (irq_cond == 16'h0000 && !nmi_cond |=> !vec_out.valid)
    else $error("offer without condition");
  // Non-maskable offer one cycle after it rises
  AST_NMI_UP: assert property ($rose(nmi_cond) && !vec_ack |=> vec_out.valid
    && vec_out.cls == mip_pkg::MIP_CLS_NMI) else $error("non-maskable not offered");
  // Non-maskable vector sits in either section
  AST_NMI_SECT: assert property (vec_out.valid && vec_out.cls == mip_pkg::MIP_CLS_NMI
    |-> vec_out.addr == 16'h0002 || vec_out.addr == 16'h4002) else $error("bad nmi vector");
  // Running high handler blocks all ordinary levels
  AST_HIGH_HOLD: assert property (vec_ack && vec_out.cls == mip_pkg::MIP_CLS_HIGH ##1 !vec_done
    |=> !(vec_out.valid && vec_out.cls != mip_pkg::MIP_CLS_NMI)) else $error("nested under high");
  // Running medium handler lets only high and non-maskable through
  AST_MED_HOLD: assert property (vec_ack && vec_out.cls == mip_pkg::MIP_CLS_MED ##1 !vec_done
    |=> !(vec_out.valid && vec_out.cls <= mip_pkg::MIP_CLS_MED)) else $error("nested under med");
  // Low handler never nests another low one
  AST_LOW_HOLD: assert property (vec_ack && vec_out.cls == mip_pkg::MIP_CLS_LOW ##1 !vec_done
    |=> !(vec_out.valid && vec_out.cls == mip_pkg::MIP_CLS_LOW)) else $error("low nested");
endmodule : mip_checker

bind mip_multilevel_request_arbiter mip_checker chk_u (
  .sys_clk  (sys_clk),
  .rst_b    (rst_b),
  .irq_cond (irq_cond),
  .nmi_cond (nmi_cond),
  .vec_out  (vec_out),
  .vec_ack  (vec_ack),
  .vec_done (vec_done)
);

// [mip_consts.svh]
// Register offsets, field positions and reset values of the
// multilevel interrupt prioritizer.
// Assumes inclusion by its bare name from design files.
`ifndef MIP_CONSTS_SVH
`define MIP_CONSTS_SVH

// Byte offsets on the register bus
`define MIP_OFS_CTRL    8'h00
`define MIP_OFS_STATUS  8'h04
`define MIP_OFS_ENABLE  8'h08
`define MIP_OFS_LEVEL   8'h0c
`define MIP_OFS_PEND    8'h10
`define MIP_OFS_BASE0   8'h14
`define MIP_OFS_BASE1   8'h18
`define MIP_OFS_BASE2   8'h1c
`define MIP_OFS_BASE3   8'h20

// Control fields
`define MIP_CTRL_RR_BIT   0
`define MIP_CTRL_BOOT_BIT 1

// Status fields
`define MIP_STAT_ACT_LSB  0
`define MIP_STAT_RR_LSB   8

// Reset values
`define MIP_RST_CTRL    2'h0
`define MIP_RST_ENABLE  16'h0000
`define MIP_RST_LEVEL   32'h0000_0000
`define MIP_RST_BASE0   16'h0004
`define MIP_RST_BASE1   16'h000c
`define MIP_RST_BASE2   16'h0014
`define MIP_RST_BASE3   16'h001c
`define MIP_RST_RR      4'hf

// Vector geometry, in program-memory words
`define MIP_APP_BASE    16'h0000
`define MIP_BOOT_BASE   16'h4000
`define MIP_NMI_OFS     16'h0002
`define MIP_VEC_STEP    16'h0002

// Bus answers
`define MIP_RESP_OKAY   2'h0
`define MIP_RESP_SLVERR 2'h2

`endif

// [mip_core_model.sv]
// Core model: loads offered vectors, promptly or after a wait.
// Assumes the prioritizer's sys_clk; handler returns come from the bench.
`timescale 1ns/1ps
module mip_core_model (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire mip_pkg::mip_vec_t vec_out,
  input  wire logic [3:0]        ack_wait,
  output logic                   vec_ack,
  output logic [15:0]            took_addr,
  output logic [7:0]             took_cnt
);
  logic [3:0] wait_reg;

  // Loads only a standing offer, once it stood long enough
  assign vec_ack = vec_out.valid && wait_reg >= ack_wait;

  // Age of the current offer; a slow core lets it stand
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) wait_reg <= 4'h0;
    else if (!vec_out.valid || vec_ack) wait_reg <= 4'h0;
    else wait_reg <= wait_reg + 4'h1;
  end

  // Program counter value and number of loads
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      took_addr <= 16'h0000;
      took_cnt  <= 8'h00;
    end else if (vec_ack) begin
      took_addr <= vec_out.addr;
      took_cnt  <= took_cnt + 8'h01;
    end
  end
endmodule : mip_core_model

// [mip_multilevel_request_arbiter.sv]
// Multilevel interrupt prioritizer with an AXI4-Lite register slave.
// Assumes sources and core run on sys_clk; core pulses vec_ack when
// it loads the offered vector and vec_done when a handler returns.
//
// How it works
// (R1) Each source picks low, medium or high level
// (R2) Medium request preempts running low handler
// (R3) High request preempts medium or low handler
// (R4) Same level: lowest vector address wins; the code picks the lowest source index, whatever the base registers hold
// (R5) Optional round-robin among low-level requests
// (R6) Non-maskable request ignores enables and levels
// (R7) Vector is peripheral base plus offset
// (R8) Vectors are program-memory word addresses
// (R9) Request needs enable, level and condition
// (R10) Acknowledge loads offered vector into core
// (R11) Every source has own enable and level
// (R12) Vector table in application or boot section
// (R13) Not-higher requests wait for handler completion
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mip_consts.svh"

module mip_multilevel_request_arbiter (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            clk_en,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [15:0]     irq_cond,
  input  wire logic            nmi_cond,
  output mip_pkg::mip_vec_t    vec_out,
  input  wire logic            vec_ack,
  input  wire logic            vec_done
);

  logic [1:0]  ctrl_reg;
  logic [15:0] enable_reg;
  logic [31:0] level_reg;
  logic [15:0] base_reg [0:3];
  logic [3:0]  act_reg;
  logic [3:0]  act_next;
  logic [3:0]  rr_last_reg;
  logic [3:0]  idx_reg;
  logic [15:0] req;
  logic [3:1]  lv_hit;
  logic [3:0]  lv_idx [1:3];
  mip_pkg::mip_vec_t vec_next;
  logic [3:0]  idx_next;
  logic [15:0] sect_base;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] mip_merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  s
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : mip_merge

  // Raw requests from sources
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      req[i] = irq_cond[i] & enable_reg[i] // [R9] [R11]
             & (level_reg[2*i +: 2] != mip_pkg::MIP_LVL_OFF);
    end
  end

  // Per-level winner; descending scan leaves the lowest index
  always_comb begin
    for (int l = 1; l < 4; l++) begin
      lv_hit[l] = 1'b0;
      lv_idx[l] = 4'h0;
      for (int k = 15; k >= 0; k--) begin
        if (req[k] && level_reg[2*k +: 2] == 2'(l)) begin // [R1]
          lv_hit[l] = 1'b1;
          lv_idx[l] = 4'(k); // [R4]
        end
      end
    end
    // Low level with round-robin on: scan starts just after the last served source
    if (ctrl_reg[`MIP_CTRL_RR_BIT]) begin
      lv_hit[1] = 1'b0;
      lv_idx[1] = 4'h0;
      for (int k = 15; k >= 0; k--) begin
        if (req[4'(rr_last_reg + 4'(k) + 4'h1)]
            && level_reg[2*(4'(rr_last_reg + 4'(k) + 4'h1)) +: 2]
               == mip_pkg::MIP_LVL_LOW) begin
          lv_hit[1] = 1'b1;
          lv_idx[1] = 4'(rr_last_reg + 4'(k) + 4'h1); // [R5]
        end
      end
    end
  end

  // Section of program memory holding the table
  assign sect_base = ctrl_reg[`MIP_CTRL_BOOT_BIT] ?
                     `MIP_BOOT_BASE : `MIP_APP_BASE; // [R12]

  // Pick what may preempt the running handler, if anything
  always_comb begin
    vec_next = '0;
    idx_next = idx_reg;
    if (nmi_cond && !act_reg[3]) begin
      vec_next.valid = 1'b1; // [R6]
      vec_next.cls   = mip_pkg::MIP_CLS_NMI;
    end else if (lv_hit[3] && act_reg[3:2] == 2'h0) begin
      vec_next.valid = 1'b1; // [R3]
      vec_next.cls   = mip_pkg::MIP_CLS_HIGH;
      idx_next       = lv_idx[3];
    end else if (lv_hit[2] && act_reg[3:1] == 3'h0) begin
      vec_next.valid = 1'b1; // [R2]
      vec_next.cls   = mip_pkg::MIP_CLS_MED;
      idx_next       = lv_idx[2];
    end else if (lv_hit[1] && act_reg == 4'h0) begin
      vec_next.valid = 1'b1; // [R13]
      vec_next.cls   = mip_pkg::MIP_CLS_LOW;
      idx_next       = lv_idx[1];
    end
    // Word address: section + peripheral base + interrupt offset; non-maskable: section + its fixed offset
    if (vec_next.cls == mip_pkg::MIP_CLS_NMI) begin
      vec_next.addr = sect_base + `MIP_NMI_OFS; // [R8]
    end else begin
      vec_next.addr = sect_base + base_reg[idx_next[3:2]]
                    + 16'(idx_next[1:0]) * `MIP_VEC_STEP; // [R7] [R8]
    end
    // The taken vector must not be offered again next cycle
    if (vec_ack) begin
      vec_next = '0;
    end
  end

  // Handler nesting: return clears the top, acknowledge sets a bit
  always_comb begin
    act_next = act_reg;
    if (vec_done) begin
      if (act_reg[3]) begin
        act_next[3] = 1'b0;
      end else if (act_reg[2]) begin
        act_next[2] = 1'b0;
      end else if (act_reg[1]) begin
        act_next[1] = 1'b0;
      end else begin
        act_next[0] = 1'b0;
      end
    end
    if (vec_ack && vec_out.valid) begin
      unique case (vec_out.cls)
        mip_pkg::MIP_CLS_NMI:  act_next[3] = 1'b1;
        mip_pkg::MIP_CLS_HIGH: act_next[2] = 1'b1;
        mip_pkg::MIP_CLS_MED:  act_next[1] = 1'b1;
        mip_pkg::MIP_CLS_LOW:  act_next[0] = 1'b1;
        default:               act_next = act_next;
      endcase
    end
  end

  // Offered vector; registered so the core sees a clean level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_out <= '0;
      idx_reg <= 4'h0;
    end else if (clk_en) begin
      vec_out <= vec_next; // [R10]
      idx_reg <= idx_next;
    end
  end

  // Running-level record
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_reg <= 4'h0;
    end else if (clk_en) begin
      act_reg <= act_next; // [R13]
    end
  end

  // Round-robin pointer moves only when a low request is taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rr_last_reg <= `MIP_RST_RR;
    end else if (clk_en) begin
      if (vec_ack && vec_out.valid
          && vec_out.cls == mip_pkg::MIP_CLS_LOW) begin
        rr_last_reg <= idx_reg; // [R5]
      end
    end
  end

  // Write channel: ready raised once both address and data wait
  assign wr_go = s_axi_awvalid && s_axi_wvalid
               && s_axi_awready && s_axi_wready;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MIP_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                   && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
      end
    end
  end

  // Read-only words accept writes silently
  always_comb begin
    unique case (s_axi_awaddr)
      `MIP_OFS_CTRL, `MIP_OFS_STATUS, `MIP_OFS_ENABLE,
      `MIP_OFS_LEVEL, `MIP_OFS_PEND, `MIP_OFS_BASE0,
      `MIP_OFS_BASE1, `MIP_OFS_BASE2, `MIP_OFS_BASE3: wr_hit = 1'b1;
      default:                                       wr_hit = 1'b0;
    endcase
  end

  // Software-written configuration
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= `MIP_RST_CTRL;
      enable_reg  <= `MIP_RST_ENABLE;
      level_reg   <= `MIP_RST_LEVEL;
      base_reg[0] <= `MIP_RST_BASE0;
      base_reg[1] <= `MIP_RST_BASE1;
      base_reg[2] <= `MIP_RST_BASE2;
      base_reg[3] <= `MIP_RST_BASE3;
    end else if (clk_en && wr_go) begin
      unique case (s_axi_awaddr)
        `MIP_OFS_CTRL:
          ctrl_reg <= 2'(mip_merge(32'(ctrl_reg), s_axi_wdata, s_axi_wstrb));
        `MIP_OFS_ENABLE: // [R11]
          enable_reg <= 16'(mip_merge(32'(enable_reg), s_axi_wdata,
                                      s_axi_wstrb));
        `MIP_OFS_LEVEL: // [R1] [R11]
          level_reg <= mip_merge(level_reg, s_axi_wdata, s_axi_wstrb);
        `MIP_OFS_BASE0:
          base_reg[0] <= 16'(mip_merge(32'(base_reg[0]), s_axi_wdata,
                                       s_axi_wstrb));
        `MIP_OFS_BASE1:
          base_reg[1] <= 16'(mip_merge(32'(base_reg[1]), s_axi_wdata,
                                       s_axi_wstrb));
        `MIP_OFS_BASE2:
          base_reg[2] <= 16'(mip_merge(32'(base_reg[2]), s_axi_wdata,
                                       s_axi_wstrb));
        `MIP_OFS_BASE3:
          base_reg[3] <= 16'(mip_merge(32'(base_reg[3]), s_axi_wdata,
                                       s_axi_wstrb));
        default: ;
      endcase
    end
  end

  // Read decode; unmapped words read zero with an error answer
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      `MIP_OFS_CTRL:   rd_data = 32'(ctrl_reg);
      `MIP_OFS_STATUS: begin
        rd_data[`MIP_STAT_ACT_LSB +: 4] = act_reg;
        rd_data[`MIP_STAT_RR_LSB +: 4]  = rr_last_reg;
      end
      `MIP_OFS_ENABLE: rd_data = 32'(enable_reg);
      `MIP_OFS_LEVEL:  rd_data = level_reg;
      `MIP_OFS_PEND:   rd_data = 32'(req);
      `MIP_OFS_BASE0:  rd_data = 32'(base_reg[0]);
      `MIP_OFS_BASE1:  rd_data = 32'(base_reg[1]);
      `MIP_OFS_BASE2:  rd_data = 32'(base_reg[2]);
      `MIP_OFS_BASE3:  rd_data = 32'(base_reg[3]);
      default:         rd_hit  = 1'b0;
    endcase
  end

  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Read channel: one read at a time, data held until taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MIP_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_hit ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

endmodule : mip_multilevel_request_arbiter

// [mip_pkg.sv]
// Types shared by the multilevel interrupt prioritizer.
// Assumes nothing of its surroundings.
package mip_pkg;

  // Per-source level setting
  typedef enum logic [1:0] {
    MIP_LVL_OFF  = 2'b00,
    MIP_LVL_LOW  = 2'b01,
    MIP_LVL_MED  = 2'b10,
    MIP_LVL_HIGH = 2'b11
  } mip_lvl_t;

  // Class of an offered vector
  typedef enum logic [2:0] {
    MIP_CLS_NONE = 3'b000,
    MIP_CLS_LOW  = 3'b001,
    MIP_CLS_MED  = 3'b010,
    MIP_CLS_HIGH = 3'b011,
    MIP_CLS_NMI  = 3'b100
  } mip_cls_t;

  // Vector offered to the core
  typedef struct packed {
    logic        valid;
    mip_cls_t    cls;
    logic [15:0] addr;
  } mip_vec_t;

endpackage : mip_pkg

// [tb_multilevel_interrupt_prioritizer.sv]
// Testbench of the prioritizer: AXI4-Lite tasks, core model, sources.
// Assumes the checker binds itself; clk_en and wstrb move only in the main sequence.
`timescale 1ns/1ps
`include "mip_consts.svh"
module tb_multilevel_interrupt_prioritizer;
  logic              sys_clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, vec_done = 1'h0;
  logic              nmi_cond = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic              s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, vec_ack;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, took_cnt, exp_n = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf, ack_wait = 4'h0;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [15:0]       irq_cond = 16'h0000, took_addr;
  mip_pkg::mip_vec_t vec_out;
  int                bad_count = 0, checks = 0, cyc = 0;

  mip_multilevel_request_arbiter dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_cond(irq_cond),
    .nmi_cond(nmi_cond), .vec_out(vec_out), .vec_ack(vec_ack), .vec_done(vec_done));
  mip_core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b), .vec_out(vec_out),
    .ack_wait(ack_wait), .vec_ack(vec_ack), .took_addr(took_addr), .took_cnt(took_cnt));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write: address and data offered together, each held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid  <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready  <= 1'h0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    @(posedge sys_clk);
  endtask : wr

  task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready  <= 1'h0;
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    @(posedge sys_clk);
  endtask : rdr

  // Next load expected, with its word address
  task automatic svc(input logic [15:0] exp);
    exp_n = exp_n + 8'h01;
    repeat (40) if (took_cnt != exp_n) @(posedge sys_clk);
    chk("vector", 32'(took_addr), 32'(exp));
    chk("loads", 32'(took_cnt), 32'(exp_n));
  endtask : svc

  // Nothing may be loaded for k cycles
  task automatic quiet(input int k);
    repeat (k) @(posedge sys_clk);
    chk("loads", 32'(took_cnt), 32'(exp_n));
  endtask : quiet

  // Handler return pulse
  task automatic ret();
    vec_done <= 1'h1;
    @(posedge sys_clk);
    vec_done <= 1'h0;
    @(posedge sys_clk);
  endtask : ret

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    rdr(`MIP_OFS_CTRL, 32'h0, `MIP_RESP_OKAY);
    rdr(`MIP_OFS_ENABLE, 32'h0, `MIP_RESP_OKAY);
    rdr(`MIP_OFS_LEVEL, 32'h0, `MIP_RESP_OKAY);
    for (int i = 0; i < 4; i++) rdr(8'h14 + 8'(4 * i), 32'h4 + 32'(8 * i), `MIP_RESP_OKAY);
    rdr(8'h40, 32'h0, `MIP_RESP_SLVERR);
    wr(8'h40, 32'hffff, `MIP_RESP_SLVERR);
    wr(`MIP_OFS_ENABLE, 32'hffff, `MIP_RESP_OKAY);
    wr(`MIP_OFS_LEVEL, 32'h555d5559, `MIP_RESP_OKAY);
    rdr(`MIP_OFS_LEVEL, 32'h555d5559, `MIP_RESP_OKAY);
    // Two low requests: lowest vector first, other waits; frozen enable holds all off
    clk_en   <= 1'h0;
    irq_cond <= 16'h0024;
    quiet(6);
    clk_en   <= 1'h1;
    svc(16'h0008);
    irq_cond <= 16'h0020;
    quiet(6);
    rdr(`MIP_OFS_STATUS, 32'h0000_0201, `MIP_RESP_OKAY);
    rdr(`MIP_OFS_PEND, 32'h0000_0020, `MIP_RESP_OKAY);
    wr(`MIP_OFS_PEND, 32'hffff, `MIP_RESP_OKAY);
    ret();
    svc(16'h000e);
    irq_cond <= 16'h0000;
    ret();
    // Low, then medium, then high nest; a new low waits for all
    irq_cond <= 16'h0001;
    svc(16'h0004);
    irq_cond <= 16'h0002;
    svc(16'h0006);
    irq_cond <= 16'h0200;
    svc(16'h0016);
    irq_cond <= 16'h0008;
    quiet(6);
    ret();
    ret();
    quiet(4);
    ret();
    svc(16'h000a);
    irq_cond <= 16'h0000;
    ret();
    // Disabled source stays silent until enabled
    // Low byte lane only, so the upper enables keep their value
    s_axi_wstrb <= 4'h1;
    wr(`MIP_OFS_ENABLE, 32'h0000_007f, `MIP_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdr(`MIP_OFS_ENABLE, 32'h0000_ff7f, `MIP_RESP_OKAY);
    irq_cond <= 16'h0080;
    quiet(6);
    rdr(`MIP_OFS_PEND, 32'h0000_0000, `MIP_RESP_OKAY);
    wr(`MIP_OFS_ENABLE, 32'hffff, `MIP_RESP_OKAY);
    svc(16'h0012);
    irq_cond <= 16'h0000;
    ret();
    // Non-maskable with all enables off, both sections
    wr(`MIP_OFS_ENABLE, 32'h0, `MIP_RESP_OKAY);
    nmi_cond <= 1'h1;
    svc(16'h0002);
    nmi_cond <= 1'h0;
    ret();
    wr(`MIP_OFS_CTRL, 32'h2, `MIP_RESP_OKAY);
    nmi_cond <= 1'h1;
    svc(16'h4002);
    nmi_cond <= 1'h0;
    ret();
    // Round robin with a slow core: low sources take turns
    ack_wait <= 4'h3;
    wr(`MIP_OFS_ENABLE, 32'hffff, `MIP_RESP_OKAY);
    wr(`MIP_OFS_CTRL, 32'h1, `MIP_RESP_OKAY);
    irq_cond <= 16'h0005;
    svc(16'h0004);
    ret();
    svc(16'h0008);
    ret();
    svc(16'h0004);
    irq_cond <= 16'h0000;
    ret();
    final_report();
  end
endmodule : tb_multilevel_interrupt_prioritizer
